// file: pkg/gcfg_pkg.sv
// Purpose: shared constants and carriers for the global configuration flag block
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes: write address carries the top bit set; reads use the plain address
package gcfg_pkg;

  localparam int          GCFG_FLAGS_W     = 17;
  localparam logic [7:0]  GCFG_ADDR_FLAGS  = 8'h00;
  localparam logic [7:0]  GCFG_ADDR_STATUS = 8'h01;
  localparam logic [7:0]  GCFG_WRITE_ADD   = 8'h80;
  localparam logic [16:0] GCFG_FLAGS_RESET = 17'h00008;
  localparam logic [31:0] GCFG_RDATA_ZERO  = 32'h00000000;

  localparam int GCFG_BIT_RECAL      = 0;
  localparam int GCFG_BIT_FAST_IDLE  = 1;
  localparam int GCFG_BIT_QUIET_PWM  = 2;
  localparam int GCFG_BIT_STEP_FILT  = 3;
  localparam int GCFG_BIT_INVERT_DIR = 4;
  localparam int GCFG_BIT_DIAG0_FLT  = 5;

  localparam int GCFG_IDLE_SHORT_CYC  = 2 ** 18;
  localparam int GCFG_IDLE_NORMAL_CYC = 2 ** 20;
  localparam int GCFG_SYNC_STAGES     = 3;

  typedef struct packed {
    logic        valid;
    logic [7:0]  addrByte;
    logic [31:0] wrData;
  } gcfg_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdData;
  } gcfg_rsp_t;

  typedef struct packed {
    logic overTemp;
    logic shortToGnd;
    logic pumpUnderVolt;
  } gcfg_fault_t;

endpackage : gcfg_pkg

// file: rtl/gcfg_sync3.sv
// Purpose: three-flop pin synchroniser with agreement filter
// Assumes: input is asynchronous to sys_clk
// Notes: output follows once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module gcfg_sync3
  import gcfg_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // pin and filtered level
  input  wire logic pinIn,
  input  wire logic resetLevel,
  output logic      levelOut
);
  logic [GCFG_SYNC_STAGES-1:0] stage_r;

  // the first stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stage_r <= {GCFG_SYNC_STAGES{resetLevel}};
    end else begin
      stage_r <= {stage_r[GCFG_SYNC_STAGES-2:0], pinIn};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      levelOut <= resetLevel;
    end else if (stage_r[1] == stage_r[2]) begin
      levelOut <= stage_r[2];
    end
  end

endmodule : gcfg_sync3
`default_nettype wire

// file: rtl/gcfg_flags.sv
// Purpose: global configuration flag register and the driver controls it steers
// Assumes: register access arrives as decoded serial datagrams, one per request
// Notes: idle timeouts are parameters so simulation can shorten them
//
// Summary of operation
// - all registers clear at reset except the flag default, diagOut0Active and the enable pin synchroniser, which set
// - address with top bit set writes; plain address reads
// - recalibrate zero crossing while driver disabled by pin or zero off-time
// - standstill after 2^18 idle clocks when fast bit set, else 2^20
// - quiet pwm enable bit; turn on only at standstill with equal currents
// - step input filter enable bit, defaults to one
// - invert bit reverses motor direction relative to command
// - in external step mode, first diagnostic output flags driver faults
`timescale 1ns/1ps
`default_nettype none
module gcfg_flags
  import gcfg_pkg::*;
#(
  parameter int IDLE_SHORT_CYC  = GCFG_IDLE_SHORT_CYC,
  parameter int IDLE_NORMAL_CYC = GCFG_IDLE_NORMAL_CYC
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // register access
  input  wire gcfg_req_t   regReq,
  output gcfg_rsp_t        regRsp,
  // driver pins and chopper state
  input  wire logic        driverEnable_n,
  input  wire logic        stepPin,
  input  wire logic [3:0]  chopperOffTime,
  input  wire logic [4:0]  standstillCurrent,
  input  wire logic [4:0]  runCurrent,
  input  wire logic        pwmVelocityOk,
  input  wire logic        cmdDirection,
  input  wire logic        extStepDirSelect,
  input  wire gcfg_fault_t driverFault,
  // controls
  output logic             zeroCrossRecal,
  output logic             standstill,
  output logic             quietPwmActive,
  output logic             stepFilterEn,
  output logic             motorDirection,
  output logic             diagOut0Active
);
  localparam int CNT_W = $clog2(IDLE_NORMAL_CYC + 1);

  generate
    if (IDLE_SHORT_CYC < 1 || IDLE_SHORT_CYC > IDLE_NORMAL_CYC) begin : g_bad
      $error("idle timeouts must satisfy 1 <= short <= normal");
    end
  endgenerate

  logic [GCFG_FLAGS_W-1:0] flags_r;
  logic [CNT_W-1:0]        idleCnt_r;
  logic [CNT_W-1:0]        idleLimit;
  logic                    enPinLevel;
  logic                    stepLevel;
  logic                    stepLevelDly_r;
  logic                    stepEdge;
  logic                    wrHit;
  logic                    rdFlags;
  logic                    rdStatus;

  // enable pin idles high: start out disabled so no false enable follows reset
  gcfg_sync3 u_sync_enable (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .pinIn      (driverEnable_n),
    .resetLevel (1'b1),
    .levelOut   (enPinLevel)
  );

  gcfg_sync3 u_sync_step (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .pinIn      (stepPin),
    .resetLevel (1'b0),
    .levelOut   (stepLevel)
  );

  assign wrHit    = regReq.valid && regReq.addrByte == (GCFG_ADDR_FLAGS | GCFG_WRITE_ADD);
  assign rdFlags  = regReq.valid && regReq.addrByte == GCFG_ADDR_FLAGS;
  assign rdStatus = regReq.valid && regReq.addrByte == GCFG_ADDR_STATUS;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      flags_r <= GCFG_FLAGS_RESET;
    end else if (wrHit) begin
      flags_r <= regReq.wrData[GCFG_FLAGS_W-1:0];
    end
  end

  // read answer one cycle after the request; unmapped reads and writes answer zero
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      regRsp <= '0;
    end else begin
      regRsp.valid <= regReq.valid;
      if (rdFlags) begin
        regRsp.rdData <= {15'h0000, flags_r};
      end else if (rdStatus) begin
        regRsp.rdData <= {28'h0000000, diagOut0Active, zeroCrossRecal, quietPwmActive, standstill};
      end else begin
        regRsp.rdData <= GCFG_RDATA_ZERO;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      zeroCrossRecal <= 1'b0;
    end else begin
      zeroCrossRecal <= flags_r[GCFG_BIT_RECAL] && (enPinLevel || chopperOffTime == 4'h0);
    end
  end

  assign stepEdge  = stepLevel && !stepLevelDly_r;
  assign idleLimit = flags_r[GCFG_BIT_FAST_IDLE] ? CNT_W'(IDLE_SHORT_CYC) : CNT_W'(IDLE_NORMAL_CYC);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stepLevelDly_r <= 1'b0;
    end else begin
      stepLevelDly_r <= stepLevel;
    end
  end

  // counter stops at one below the limit so a later switch of the fast bit still resolves
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      idleCnt_r  <= '0;
      standstill <= 1'b0;
    end else if (stepEdge) begin
      idleCnt_r  <= '0;
      standstill <= 1'b0;
    end else if (idleCnt_r >= idleLimit - CNT_W'(1)) begin
      standstill <= 1'b1;
    end else begin
      idleCnt_r <= idleCnt_r + CNT_W'(1);
    end
  end

  // off-to-on only when stopped with matching currents; hardware holds it off otherwise
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      quietPwmActive <= 1'b0;
    end else if (!flags_r[GCFG_BIT_QUIET_PWM] || !pwmVelocityOk) begin
      quietPwmActive <= 1'b0;
    end else if (standstill && standstillCurrent == runCurrent) begin
      quietPwmActive <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stepFilterEn   <= 1'b0;
      motorDirection <= 1'b0;
    end else begin
      stepFilterEn   <= flags_r[GCFG_BIT_STEP_FILT];
      motorDirection <= cmdDirection ^ flags_r[GCFG_BIT_INVERT_DIR];
    end
  end

  // active during reset, as the diagnostic pin shows the reset state
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      diagOut0Active <= 1'b1;
    end else begin
      diagOut0Active <= extStepDirSelect && flags_r[GCFG_BIT_DIAG0_FLT] &&
                        (driverFault.overTemp || driverFault.shortToGnd || driverFault.pumpUnderVolt);
    end
  end

  sequence s_flagWrite;
    wrHit;
  endsequence

  sequence s_flagsLoaded;
    flags_r == $past(regReq.wrData[GCFG_FLAGS_W-1:0]);
  endsequence

  AST_RESET_DEFAULT: assert property (@(posedge sys_clk) !reset_n |=> flags_r == GCFG_FLAGS_RESET)
    else $error("flags not at default after reset");
  AST_WRITE_LOADS: assert property (@(posedge sys_clk) disable iff (!reset_n) s_flagWrite |=> s_flagsLoaded)
    else $error("write to flags not stored");
  AST_READ_NO_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
      rdFlags |=> $stable(flags_r) ##0 regRsp.rdData == {15'h0000, flags_r})
    else $error("plain address altered flags or read wrong");
  AST_RECAL: assert property (@(posedge sys_clk) disable iff (!reset_n)
      flags_r[GCFG_BIT_RECAL] && chopperOffTime == 4'h0 |=> zeroCrossRecal)
    else $error("no recalibration with zero off-time");
  AST_IDLE_SHORT: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(standstill) |-> idleCnt_r >= idleLimit - CNT_W'(1))
    else $error("standstill declared early");
  AST_STEP_CLEARS: assert property (@(posedge sys_clk) disable iff (!reset_n) stepEdge |=> !standstill)
    else $error("step did not clear standstill");
  AST_PWM_ON: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(quietPwmActive) |-> $past(standstill) && $past(flags_r[GCFG_BIT_QUIET_PWM]))
    else $error("quiet pwm turned on while moving");
  AST_FILTER: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_flagWrite |=> ##1 stepFilterEn == $past(regReq.wrData[GCFG_BIT_STEP_FILT], 2))
    else $error("filter enable not following flag");
  AST_DIRECTION: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reset_n |=> motorDirection == ($past(cmdDirection) ^ $past(flags_r[GCFG_BIT_INVERT_DIR])))
    else $error("direction inversion wrong");
  AST_DIAG0: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reset_n && !extStepDirSelect |=> !diagOut0Active)
    else $error("diagnostic active outside external step mode");

endmodule : gcfg_flags
`default_nettype wire

// file: verif/gcfg_host.sv
// Purpose: host side of the flag register access, one request per call
// Assumes: request driven just after a rising edge, answer valid one cycle after take
// Notes: gives up after four cycles without an answer and reports that to the caller
`timescale 1ns/1ps
`default_nettype none
module gcfg_host
  import gcfg_pkg::*;
(
  // clock
  input  wire logic      sys_clk,
  // register access
  output var  gcfg_req_t regReq,
  input  wire gcfg_rsp_t regRsp
);
  initial regReq = '0;

  task automatic xfer(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output bit ok);
    int i;
    @(posedge sys_clk);
    regReq <= '{1'b1, a, d};
    @(posedge sys_clk);
    regReq <= '0;
    ok = 1'b0;
    q  = '0;
    for (i = 0; i < 4 && !ok; i++) begin
      #1;
      if (regRsp.valid === 1'b1) begin
        ok = 1'b1;
        q  = regRsp.rdData;
      end else begin
        @(posedge sys_clk);
      end
    end
  endtask : xfer
endmodule : gcfg_host
`default_nettype wire

// file: verif/tb.sv
// Purpose: self-checking bench for the global configuration flag block
// Assumes: idle limits shortened to 16 and 64 cycles
// Notes: model holds the flag word as the host last wrote it
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gcfg_pkg::*;
  logic        sys_clk = 1'b0, reset_n = 1'b0;
  gcfg_req_t   regReq;
  gcfg_rsp_t   regRsp;
  logic        drvEn_n = 1'b1, stepPin = 1'b0, velOk = 1'b1, cmdDir = 1'b0, extSel = 1'b0;
  logic [3:0]  offTime = 4'h5;
  logic [4:0]  holdCur = 5'h0a, runCur = 5'h0a;
  gcfg_fault_t fault = '0;
  logic        zc, ss, qp, sf, md, d0;
  int          err_total = 0, n_tests = 0, seed = 32'h874b, n, i;
  logic [31:0] model, q;
  bit          ok;

  gcfg_flags #(.IDLE_SHORT_CYC(16), .IDLE_NORMAL_CYC(64)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .regReq(regReq), .regRsp(regRsp), .driverEnable_n(drvEn_n), .stepPin(stepPin), .chopperOffTime(offTime),
    .standstillCurrent(holdCur), .runCurrent(runCur), .pwmVelocityOk(velOk), .cmdDirection(cmdDir),
    .extStepDirSelect(extSel), .driverFault(fault), .zeroCrossRecal(zc), .standstill(ss),
    .quietPwmActive(qp), .stepFilterEn(sf), .motorDirection(md), .diagOut0Active(d0));
  gcfg_host host (.sys_clk(sys_clk), .regReq(regReq), .regRsp(regRsp));

  task automatic conclude();
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic acc(input logic [7:0] a, input logic [31:0] d);
    host.xfer(a, d, q, ok);
    if (!ok) begin
      err_total++;
      conclude();
    end
  endtask : acc
  task automatic wr(input logic [16:0] d);
    acc(GCFG_ADDR_FLAGS + GCFG_WRITE_ADD, {15'h0, d});
    model = {15'h0, d};
    chk(q, 32'h0, "write answer");
  endtask : wr
  task automatic rd(input logic [31:0] exp);
    acc(GCFG_ADDR_FLAGS, 32'h0);
    chk(q, exp, "flags read");
  endtask : rd
  // the step is held well past the sync delay so it cannot be missed
  task automatic idle(input bit fast);
    wr(fast ? 17'h0000a : 17'h00008);
    @(posedge sys_clk);
    stepPin <= 1'b1;
    cyc(6);
    chk(ss, 32'h0, "standstill after step");
    @(posedge sys_clk);
    stepPin <= 1'b0;
    for (n = 7; n < 200 && ss !== 1'b1; n++) cyc(1);
    chk(n >= (fast ? 16 : 64) && n <= (fast ? 26 : 74), 32'h1, "idle time");
  endtask : idle

  initial forever #5 sys_clk = ~sys_clk;
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_total++;
    conclude();
  end
  initial begin
    repeat (7) @(posedge sys_clk);
    #1;
    chk(d0, 32'h1, "diag in reset");
    @(posedge sys_clk);
    reset_n <= 1'b1;
    cyc(1);
    chk({zc, qp, md}, 32'h0, "controls after reset");
    chk(sf, 32'h1, "filter default");
    rd(32'h00000008);
    wr(17'($random(seed)));
    rd(model);
    acc(8'h81, 32'h0001ffff);
    chk(q, 32'h0, "unmapped answer");
    rd(model);
    for (i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      cmdDir <= 1'($random(seed));
      wr(i[0] ? 17'h00018 : 17'h00008);
      cyc(3);
      chk(md, cmdDir ^ i[0], "direction");
    end
    @(posedge sys_clk);
    drvEn_n <= 1'b0;
    wr(17'h00009);
    cyc(8);
    chk(zc, 32'h0, "no recal when enabled");
    @(posedge sys_clk);
    offTime <= 4'h0;
    cyc(3);
    chk(zc, 32'h1, "recal by off time");
    @(posedge sys_clk);
    offTime <= 4'h5;
    cyc(3);
    chk(zc, 32'h0, "recal ends with off time");
    @(posedge sys_clk);
    drvEn_n <= 1'b1;
    cyc(8);
    chk(zc, 32'h1, "recal by pin");
    wr(17'h00008);
    cyc(3);
    chk(zc, 32'h0, "recal off");
    idle(1'b1);
    idle(1'b0);
    wr(17'h0000c);
    cyc(3);
    chk(qp, 32'h1, "quiet on at standstill");
    acc(GCFG_ADDR_STATUS, 32'h0);
    chk(q, 32'h00000003, "status word");
    @(posedge sys_clk);
    velOk <= 1'b0;
    cyc(3);
    chk(qp, 32'h0, "quiet off above velocity");
    @(posedge sys_clk);
    velOk <= 1'b1;
    wr(17'h00008);
    cyc(3);
    chk(qp, 32'h0, "quiet off");
    @(posedge sys_clk);
    holdCur <= 5'h05;
    wr(17'h0000c);
    cyc(3);
    chk(qp, 32'h0, "quiet refused on current mismatch");
    @(posedge sys_clk);
    extSel <= 1'b1;
    fault  <= gcfg_fault_t'(3'($random(seed)) | 3'h1);
    wr(17'h00028);
    cyc(3);
    chk(d0, 32'h1, "diag on fault");
    @(posedge sys_clk);
    extSel <= 1'b0;
    cyc(3);
    chk(d0, 32'h0, "diag held off outside external mode");
    @(posedge sys_clk);
    extSel <= 1'b1;
    fault <= '0;
    cyc(3);
    chk(d0, 32'h0, "diag clear");
    conclude();
  end
endmodule : tb
`default_nettype wire
